/* logic/lcr_packet_rx.sv */
`timescale 1ns/10ps
module lcr_packet_rx (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	// Serial link pins
	input  wire logic        serial_clock_in,
	input  wire logic        serial_data_in,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [31:0] reg_rdata,
	// LED channel drive, high means on
	output logic             channel_a_output,
	output logic             channel_b_output,
	output logic             channel_c_output
);

	// Synchroniser stages for the link pins
	logic              sck_meta_reg;
	logic              sck_sync_reg;
	logic              sck_last_reg;
	logic              sdi_meta_reg;
	logic              sdi_sync_reg;
	// Receiver state
	lcr_pkg::lcr_state_t st_reg;
	logic [47:0]       sr_reg;       // Serial shift register
	logic [5:0]        cnt_reg;      // Bits into current field
	logic [5:0]        hdr_reg;      // Accepted header
	logic [9:0]        len_reg;      // Chain length minus one
	logic [9:0]        grp_reg;      // Group index in packet
	lcr_pkg::lcr_rgb_t pend_reg;     // Own group, not yet shown
	logic              pend_ok_reg;  // Own group captured
	// Visible state
	lcr_pkg::lcr_rgb_t gs_reg;       // Gray scale in use
	logic              mode10_reg;   // Ten-bit PWM active
	logic [15:0]       pwm_reg;      // PWM counter
	logic [9:0]        pos_reg;      // Own chain position
	logic              en_reg;       // Receiver enable
	logic [7:0]        bad_cnt_reg;  // Rejected preambles
	logic [7:0]        good_cnt_reg; // Committed gray packets
	// Combinational helpers
	logic              sample;
	logic [47:0]       sr_next;
	logic              wide;
	logic [5:0]        frame_last;
	logic              pre_done;
	logic              pre_good;
	logic              grp_end;
	logic              pick;
	logic              commit;
	lcr_pkg::lcr_rgb_t grp_words;

	// Header decode, shared by several processes
	function automatic logic hdr_known(input logic [5:0] h);
		hdr_known = (h == lcr_pkg::HDR_GS16) || (h == lcr_pkg::HDR_GS10) ||
			(h == lcr_pkg::HDR_DC8) || (h == lcr_pkg::HDR_DC6) ||
			(h == lcr_pkg::HDR_CFG16) || (h == lcr_pkg::HDR_CFG10);
	endfunction

	// Sixteen-bit family uses wide preamble and words
	function automatic logic hdr_wide(input logic [5:0] h);
		hdr_wide = (h == lcr_pkg::HDR_GS16) || (h == lcr_pkg::HDR_DC8) || (h == lcr_pkg::HDR_CFG16);
	endfunction

	// Only gray scale packets change the outputs
	function automatic logic hdr_gray(input logic [5:0] h);
		hdr_gray = (h == lcr_pkg::HDR_GS16) || (h == lcr_pkg::HDR_GS10);
	endfunction

	// Expected parity nibble
	function automatic logic [3:0] par_calc(input logic [5:0] h, input logic [9:0] a, input logic [9:0] l);
		logic [2:0] p;
		p = {^h, ^a, ^l};
		par_calc = {^p, p};
	endfunction

	// Preamble check for either layout
	function automatic logic pre_check(input logic [47:0] s, input logic w);
		if (w) begin
			pre_check = (s[lcr_pkg::W_HDR2_LO +: 6] == s[lcr_pkg::W_HDR_LO +: 6]) &&
				(s[lcr_pkg::W_LEN2_LO +: 10] == s[lcr_pkg::W_LEN_LO +: 10]) &&
				(s[lcr_pkg::W_PAR_LO +: 4] == par_calc(s[lcr_pkg::W_HDR_LO +: 6],
				s[lcr_pkg::W_ADR_LO +: 10], s[lcr_pkg::W_LEN_LO +: 10]));
		end else begin
			pre_check = (s[lcr_pkg::N_PAR_LO +: 4] == par_calc(s[lcr_pkg::N_HDR_LO +: 6],
				s[lcr_pkg::N_ADR_LO +: 10], s[lcr_pkg::N_LEN_LO +: 10]));
		end
	endfunction

	// Link pin synchronisers; first stage feeds only the second
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sck_meta_reg <= 1'b0;
			sck_sync_reg <= 1'b0;
			sck_last_reg <= 1'b0;
			sdi_meta_reg <= 1'b0;
			sdi_sync_reg <= 1'b0;
		end else begin
			sck_meta_reg <= serial_clock_in;
			sck_sync_reg <= sck_meta_reg;
			sck_last_reg <= sck_sync_reg;
			sdi_meta_reg <= serial_data_in;
			sdi_sync_reg <= sdi_meta_reg;
		end
	end

	// Falling serial clock edge; data path has equal delay
	assign sample = sck_last_reg & ~sck_sync_reg;
	assign sr_next = {sr_reg[46:0], sdi_sync_reg};
	assign wide = hdr_wide(hdr_reg);
	assign frame_last = (wide ? lcr_pkg::WIDE_BITS : lcr_pkg::NARROW_BITS) - 6'd1;
	assign pre_done = sample && en_reg && (st_reg == lcr_pkg::ST_PRE) && (cnt_reg == frame_last);
	assign pre_good = pre_check(sr_next, wide);
	assign grp_end = sample && en_reg && (st_reg == lcr_pkg::ST_DATA) && (cnt_reg == frame_last);
	// Farthest driver comes first, so own group is len minus position
	assign pick = grp_end && (pos_reg <= len_reg) && (grp_reg == len_reg - pos_reg);
	assign commit = grp_end && (grp_reg == len_reg) && hdr_gray(hdr_reg) && (pick || pend_ok_reg);

	// Unpack the group just shifted in
	always_comb begin
		if (wide) begin
			grp_words.c = sr_next[lcr_pkg::W_C_LO +: 16];
			grp_words.b = sr_next[lcr_pkg::W_B_LO +: 16];
			grp_words.a = sr_next[15:0];
		end else begin
			grp_words.c = {6'h00, sr_next[lcr_pkg::N_C_LO +: 10]};
			grp_words.b = {6'h00, sr_next[lcr_pkg::N_B_LO +: 10]};
			grp_words.a = {6'h00, sr_next[9:0]};
		end
	end

	// Packet parser: header hunt, preamble, data groups
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg  <= lcr_pkg::ST_IDLE;
			sr_reg  <= 48'h000000000000;
			cnt_reg <= 6'h00;
			hdr_reg <= 6'h00;
			len_reg <= 10'h000;
			grp_reg <= 10'h000;
		end else if (sample && en_reg) begin
			sr_reg <= sr_next;
			unique case (st_reg)
				lcr_pkg::ST_IDLE: begin
					// A one opens a header candidate
					if (sdi_sync_reg) begin
						st_reg  <= lcr_pkg::ST_HDR;
						cnt_reg <= 6'h01;
					end
				end
				lcr_pkg::ST_HDR: begin
					cnt_reg <= cnt_reg + 6'h01;
					if (cnt_reg == lcr_pkg::HDR_BITS - 6'd1) begin
						// Unknown code: drop all six bits, hunt again
						if (hdr_known(sr_next[5:0])) begin
							st_reg  <= lcr_pkg::ST_PRE;
							hdr_reg <= sr_next[5:0];
						end else begin
							st_reg <= lcr_pkg::ST_IDLE;
						end
					end
				end
				lcr_pkg::ST_PRE: begin
					cnt_reg <= cnt_reg + 6'h01;
					if (pre_done) begin
						cnt_reg <= 6'h00;
						grp_reg <= 10'h000;
						// Failed checks fall back to hunting
						if (pre_good) begin
							st_reg  <= lcr_pkg::ST_DATA;
							len_reg <= wide ? sr_next[lcr_pkg::W_LEN_LO +: 10] : sr_next[9:0];
						end else begin
							st_reg <= lcr_pkg::ST_IDLE;
						end
					end
				end
				lcr_pkg::ST_DATA: begin
					cnt_reg <= cnt_reg + 6'h01;
					if (grp_end) begin
						cnt_reg <= 6'h00;
						grp_reg <= grp_reg + 10'h001;
						// Dot correction and configuration data skipped whole
						if (grp_reg == len_reg) begin
							st_reg <= lcr_pkg::ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Hold own group until the packet has fully arrived
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pend_reg    <= '{lcr_pkg::GS_RESET, lcr_pkg::GS_RESET, lcr_pkg::GS_RESET};
			pend_ok_reg <= 1'b0;
		end else if (pre_done) begin
			pend_ok_reg <= 1'b0;
		end else if (pick) begin
			pend_reg    <= grp_words;
			pend_ok_reg <= 1'b1;
		end
	end

	// Adopt new values only for a complete, checked gray packet
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			gs_reg     <= '{lcr_pkg::GS_RESET, lcr_pkg::GS_RESET, lcr_pkg::GS_RESET};
			mode10_reg <= 1'b0;
		end else if (commit) begin
			gs_reg     <= pick ? grp_words : pend_reg;
			mode10_reg <= ~wide;
		end
	end

	// PWM counter restarts when new values arrive
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pwm_reg <= 16'h0000;
		end else if (commit) begin
			pwm_reg <= 16'h0000;
		end else if (mode10_reg && pwm_reg[9:0] == lcr_pkg::PWM10_MAX) begin
			pwm_reg <= 16'h0000;
		end else begin
			pwm_reg <= pwm_reg + 16'h0001;
		end
	end

	// Output on while value exceeds counter; zero never lights
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			channel_a_output <= 1'b0;
			channel_b_output <= 1'b0;
			channel_c_output <= 1'b0;
		end else begin
			channel_a_output <= gs_reg.a > pwm_reg;
			channel_b_output <= gs_reg.b > pwm_reg;
			channel_c_output <= gs_reg.c > pwm_reg;
		end
	end

	// Packet counters, saturating so software sees a trend
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			bad_cnt_reg  <= 8'h00;
			good_cnt_reg <= 8'h00;
		end else begin
			if (pre_done && !pre_good && bad_cnt_reg != 8'hFF) begin
				bad_cnt_reg <= bad_cnt_reg + 8'h01;
			end
			if (commit && good_cnt_reg != 8'hFF) begin
				good_cnt_reg <= good_cnt_reg + 8'h01;
			end
		end
	end

	// Control register writes
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pos_reg <= lcr_pkg::POS_RESET;
			en_reg  <= lcr_pkg::EN_RESET;
		end else if (reg_write && reg_addr == lcr_pkg::REG_CTRL) begin
			pos_reg <= reg_wdata[9:0];
			en_reg  <= reg_wdata[lcr_pkg::CTRL_EN_BIT];
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_read) begin
			case (reg_addr)
				lcr_pkg::REG_CTRL:   reg_rdata <= {15'h0000, en_reg, 6'h00, pos_reg};
				lcr_pkg::REG_STATUS: reg_rdata <= {good_cnt_reg, bad_cnt_reg, 5'h00, mode10_reg, st_reg, 2'h0, hdr_reg};
				lcr_pkg::REG_GS_C:   reg_rdata <= {16'h0000, gs_reg.c};
				lcr_pkg::REG_GS_B:   reg_rdata <= {16'h0000, gs_reg.b};
				lcr_pkg::REG_GS_A:   reg_rdata <= {16'h0000, gs_reg.a};
				default:             reg_rdata <= 32'h00000000;
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	// Checks beside the logic
	a_idle_start_hunt: assert property (@(posedge core_clk) disable iff (!arst_n)
		(st_reg == lcr_pkg::ST_IDLE && sample && en_reg && sdi_sync_reg) |=> st_reg == lcr_pkg::ST_HDR)
		else $error("header hunt did not start on a one");
	a_bad_hdr_drop: assert property (@(posedge core_clk) disable iff (!arst_n)
		(st_reg == lcr_pkg::ST_HDR && sample && en_reg && cnt_reg == 6'd5 && !hdr_known(sr_next[5:0]))
		|=> st_reg == lcr_pkg::ST_IDLE)
		else $error("unknown header not discarded");
	a_bad_pre_keep: assert property (@(posedge core_clk) disable iff (!arst_n)
		(pre_done && !pre_good) |=> st_reg == lcr_pkg::ST_IDLE && $stable(gs_reg))
		else $error("bad preamble accepted");
	a_pwm_restart: assert property (@(posedge core_clk) disable iff (!arst_n)
		commit |=> pwm_reg == 16'h0000 ##1 pwm_reg == 16'h0001)
		else $error("PWM did not restart on new data");
	a_zero_off: assert property (@(posedge core_clk) disable iff (!arst_n)
		gs_reg.a == 16'h0000 |=> !channel_a_output)
		else $error("zero value lit channel A");
	a_ten_range: assert property (@(posedge core_clk) disable iff (!arst_n)
		mode10_reg |-> gs_reg.c[15:10] == 6'h00 && pwm_reg[15:10] == 6'h00)
		else $error("ten-bit mode exceeded 1023");
	a_gray_only: assert property (@(posedge core_clk) disable iff (!arst_n)
		!$stable(gs_reg) |-> $past(hdr_gray(hdr_reg)) && $past(grp_end))
		else $error("values changed outside a gray packet");
	a_sample_fall: assert property (@(posedge core_clk) disable iff (!arst_n)
		sample |-> $past(sck_sync_reg, 1) && $past(sck_sync_reg, 2) && !sck_sync_reg)
		else $error("sampled away from a falling edge");
	a_hdr_accept: assert property (@(posedge core_clk) disable iff (!arst_n)
		(st_reg == lcr_pkg::ST_HDR && sample && en_reg && cnt_reg == lcr_pkg::HDR_BITS - 6'd1 &&
		hdr_known(sr_next[5:0]))
		|=> st_reg == lcr_pkg::ST_PRE && hdr_reg == $past(sr_next[5:0]))
		else $error("known header not taken");
	a_hdr_copy: assert property (@(posedge core_clk) disable iff (!arst_n)
		(pre_done && pre_good && wide) |-> sr_next[lcr_pkg::W_HDR2_LO +: 6] == sr_next[lcr_pkg::W_HDR_LO +: 6])
		else $error("header copy mismatch accepted");
	a_len_copy: assert property (@(posedge core_clk) disable iff (!arst_n)
		(pre_done && pre_good && wide) |-> sr_next[lcr_pkg::W_LEN2_LO +: 10] == sr_next[lcr_pkg::W_LEN_LO +: 10])
		else $error("length copy mismatch accepted");
	// Parity written out bit by bit, apart from the shared function
	a_wide_parity: assert property (@(posedge core_clk) disable iff (!arst_n)
		(pre_done && pre_good && wide) |->
		sr_next[lcr_pkg::W_PAR_LO] == ^sr_next[lcr_pkg::W_LEN_LO +: 10] &&
		sr_next[lcr_pkg::W_PAR_LO + 1] == ^sr_next[lcr_pkg::W_ADR_LO +: 10] &&
		sr_next[lcr_pkg::W_PAR_LO + 2] == ^sr_next[lcr_pkg::W_HDR_LO +: 6] &&
		sr_next[lcr_pkg::W_PAR_LO + 3] == ^sr_next[lcr_pkg::W_PAR_LO +: 3])
		else $error("wide parity error accepted");
	a_narrow_parity: assert property (@(posedge core_clk) disable iff (!arst_n)
		(pre_done && pre_good && !wide) |->
		sr_next[lcr_pkg::N_PAR_LO] == ^sr_next[lcr_pkg::N_LEN_LO +: 10] &&
		sr_next[lcr_pkg::N_PAR_LO + 1] == ^sr_next[lcr_pkg::N_ADR_LO +: 10] &&
		sr_next[lcr_pkg::N_PAR_LO + 2] == ^sr_next[lcr_pkg::N_HDR_LO +: 6] &&
		sr_next[lcr_pkg::N_PAR_LO + 3] == ^sr_next[lcr_pkg::N_PAR_LO +: 3])
		else $error("narrow parity error accepted");
	a_data_start: assert property (@(posedge core_clk) disable iff (!arst_n)
		(pre_done && pre_good) |=> st_reg == lcr_pkg::ST_DATA && cnt_reg == 6'h00 && grp_reg == 10'h000)
		else $error("data phase did not start cleanly");
	a_commit_gray: assert property (@(posedge core_clk) disable iff (!arst_n)
		commit |-> hdr_reg == lcr_pkg::HDR_GS16 || hdr_reg == lcr_pkg::HDR_GS10)
		else $error("values taken from a non-gray packet");
	a_gray_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
		!commit |=> $stable(gs_reg))
		else $error("values changed without a commit");
	a_mode_follows: assert property (@(posedge core_clk) disable iff (!arst_n)
		commit |=> mode10_reg == ($past(hdr_reg) == lcr_pkg::HDR_GS10))
		else $error("PWM mode does not follow header");
	a_pwm_step: assert property (@(posedge core_clk) disable iff (!arst_n)
		(!mode10_reg && !commit) |=> pwm_reg == $past(pwm_reg) + 16'h0001)
		else $error("sixteen-bit PWM skipped a step");
	a_pwm_wrap: assert property (@(posedge core_clk) disable iff (!arst_n)
		(mode10_reg && pwm_reg[9:0] == lcr_pkg::PWM10_MAX && !commit) |=> pwm_reg == 16'h0000)
		else $error("ten-bit PWM did not wrap at 1023");

endmodule

/* logic/lcr_pkg.sv */
package lcr_pkg;
	// Header codes selecting the packet type
	localparam logic [5:0] HDR_GS16  = 6'h3F;
	localparam logic [5:0] HDR_GS10  = 6'h2B;
	localparam logic [5:0] HDR_DC8   = 6'h33;
	localparam logic [5:0] HDR_DC6   = 6'h27;
	localparam logic [5:0] HDR_CFG16 = 6'h23;
	localparam logic [5:0] HDR_CFG10 = 6'h37;

	// Frame geometry in serial bits
	localparam logic [5:0] HDR_BITS    = 6'd6;
	localparam logic [5:0] WIDE_BITS   = 6'd48;
	localparam logic [5:0] NARROW_BITS = 6'd30;

	// Wide preamble field positions (low bit)
	localparam int W_HDR_LO  = 42;
	localparam int W_ADR_LO  = 32;
	localparam int W_HDR2_LO = 26;
	localparam int W_LEN_LO  = 16;
	localparam int W_PAR_LO  = 12;
	localparam int W_LEN2_LO = 0;
	// Narrow preamble field positions (low bit)
	localparam int N_HDR_LO  = 24;
	localparam int N_PAR_LO  = 20;
	localparam int N_ADR_LO  = 10;
	localparam int N_LEN_LO  = 0;
	// Channel word positions inside a group
	localparam int W_C_LO = 32;
	localparam int W_B_LO = 16;
	localparam int N_C_LO = 20;
	localparam int N_B_LO = 10;

	// Register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_GS_C   = 8'h08;
	localparam logic [7:0] REG_GS_B   = 8'h0C;
	localparam logic [7:0] REG_GS_A   = 8'h10;
	// Control fields, reset values and PWM limit
	localparam int          CTRL_EN_BIT  = 16;
	localparam logic [9:0]  POS_RESET    = 10'h000;
	localparam logic        EN_RESET     = 1'b1;
	localparam logic [15:0] GS_RESET     = 16'h0000;
	localparam logic [9:0]  PWM10_MAX    = 10'h3FF;

	// Receiver states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HDR  = 2'b01,
		ST_PRE  = 2'b10,
		ST_DATA = 2'b11
	} lcr_state_t;

	// One driver's three gray scale words
	typedef struct packed {
		logic [15:0] c;
		logic [15:0] b;
		logic [15:0] a;
	} lcr_rgb_t;
endpackage

/* verification/lcr_link_model.sv */
`timescale 1ns/10ps
// Controller end of the link: builds and sends packets bit by bit
module lcr_link_model (
	// Link pins toward the receiver
	output logic serial_clock_in,
	output logic serial_data_in
);
	// Clock rests low between frames, it never runs free
	initial begin
		serial_clock_in = 1'b0;
		serial_data_in  = 1'b0;
	end

	// Send n bits MSB first; data moves at the rising edge, half a period from the sample edge
	// Non-blocking updates keep the pins clear of a race with the receiver's own clock
	task automatic send(input logic [47:0] w, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			serial_data_in  <= w[i];
			serial_clock_in <= 1'b1;
			#62.5;
			serial_clock_in <= 1'b0;
			#62.5;
		end
		// Line released: show the inverse so a stale level is never mistaken for data
		serial_data_in <= ~serial_data_in;
		// Quiet half period, so the next frame's first bit lands in a later step
		#62.5;
	endtask

	// Parity nibble over length, zero address and header; bad spoils the top bit
	function automatic logic [3:0] par(input logic [5:0] h, input logic [9:0] l, input logic bad);
		logic [3:0] p;
		p[0] = ^l;
		p[1] = 1'b0;
		p[2] = ^h;
		p[3] = (^p[2:0]) ^ bad;
		return p;
	endfunction

	// Wide preamble with the header copy and the length copy
	task automatic pre_w(input logic [5:0] h, input logic [9:0] l, input logic bad);
		send({h, 10'h000, h, l, par(h, l, bad), 2'b10, l}, 48);
	endtask

	// Narrow preamble without copies
	task automatic pre_n(input logic [5:0] h, input logic [9:0] l, input logic bad);
		send({18'h00000, h, par(h, l, bad), 10'h000, l}, 30);
	endtask
endmodule

/* verification/lcr_packet_rx_tb_top.sv */
`timescale 1ns/10ps
module lcr_packet_rx_tb_top;
	// Design pins
	logic        core_clk;
	logic        arst_n;
	logic        serial_clock_in;
	logic        serial_data_in;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_write;
	logic        reg_read;
	logic [31:0] reg_rdata;
	logic        channel_a_output;
	logic        channel_b_output;
	logic        channel_c_output;
	// Score
	int          errors;
	int          comparisons;

	lcr_packet_rx dut (.core_clk(core_clk), .arst_n(arst_n), .serial_clock_in(serial_clock_in),
		.serial_data_in(serial_data_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.channel_a_output(channel_a_output), .channel_b_output(channel_b_output),
		.channel_c_output(channel_c_output));
	lcr_link_model ctl (.serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in));

	// 250 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	task automatic tally_and_finish;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Value comparison
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (exp !== got) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One-cycle write strobe
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge core_clk);
		reg_write <= 1'b0;
	endtask

	// Read strobe, data judged in the following cycle only
	task automatic reg_rd(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge core_clk);
		reg_read <= 1'b0;
		#1;
		chk(what, exp, reg_rdata);
	endtask

	// Active gray values, after the synchronisers have caught up
	task automatic gs_chk(input logic [15:0] c, input logic [15:0] b, input logic [15:0] a);
		repeat (20) @(posedge core_clk);
		reg_rd("gs_c", lcr_pkg::REG_GS_C, {16'h0000, c});
		reg_rd("gs_b", lcr_pkg::REG_GS_B, {16'h0000, b});
		reg_rd("gs_a", lcr_pkg::REG_GS_A, {16'h0000, a});
	endtask

	// On-time of one channel over a window
	task automatic on_count(input int sel, input int win, output int n);
		logic [2:0] v;
		n = 0;
		repeat (win) begin
			@(posedge core_clk);
			#1;
			v = {channel_c_output, channel_b_output, channel_a_output};
			if (v[sel] === 1'b1)
				n++;
		end
	endtask

	// Reset values, unmapped and read-only places
	task automatic s_reset;
		reg_rd("ctrl", lcr_pkg::REG_CTRL, 32'h0001_0000);
		reg_wr(lcr_pkg::REG_GS_A, 32'h0000_5555);
		reg_wr(8'h14, 32'hFFFF_FFFF);
		gs_chk(16'h0000, 16'h0000, 16'h0000);
		reg_rd("unmapped", 8'h14, 32'h0000_0000);
	endtask

	// Wide packet, then a spoiled one that must leave values alone
	task automatic s_wide;
		int n;
		ctl.send(48'h0, 5);
		ctl.pre_w(lcr_pkg::HDR_GS16, 10'h000, 1'b0);
		ctl.send({16'h1234, 16'hABCD, 16'h0000}, 48);
		gs_chk(16'h1234, 16'hABCD, 16'h0000);
		on_count(0, 500, n);
		chk("duty_zero", 32'h0, n);
		ctl.pre_w(lcr_pkg::HDR_GS16, 10'h000, 1'b1);
		// Payload hides no valid header, so the hunt ends idle
		ctl.send({16'h1111, 16'h2222, 16'h2200}, 48);
		gs_chk(16'h1234, 16'hABCD, 16'h0000);
	endtask

	// Unknown header dropped, hunt resumes at the next one
	task automatic s_hunt;
		ctl.send(48'h21, 6);
		ctl.pre_w(lcr_pkg::HDR_GS16, 10'h000, 1'b0);
		ctl.send({16'hFFFF, 16'h8000, 16'h0001}, 48);
		gs_chk(16'hFFFF, 16'h8000, 16'h0001);
	endtask

	// Other packet types are skipped whole and leave gray values alone
	task automatic s_skip;
		logic [5:0] hd [4];
		hd = '{lcr_pkg::HDR_DC8, lcr_pkg::HDR_DC6, lcr_pkg::HDR_CFG16, lcr_pkg::HDR_CFG10};
		for (int i = 0; i < 4; i++) begin
			if (i % 2 == 0) begin
				ctl.pre_w(hd[i], 10'h000, 1'b0);
				ctl.send(48'h0, 48);
			end else begin
				ctl.pre_n(hd[i], 10'h000, 1'b0);
				ctl.send(48'h0, 30);
			end
			gs_chk(16'hFFFF, 16'h8000, 16'h0001);
		end
	endtask

	// Narrow two-driver packet, taken at each chain position
	task automatic s_narrow;
		int n;
		for (int pos = 0; pos < 2; pos++) begin
			reg_wr(lcr_pkg::REG_CTRL, 32'h0001_0000 | pos);
			ctl.pre_n(lcr_pkg::HDR_GS10, 10'h001, 1'b0);
			ctl.send({10'h3FF, 10'h001, 10'h200}, 30);
			ctl.send({10'h155, 10'h2AA, 10'h0F0}, 30);
			if (pos == 0)
				gs_chk(16'h0155, 16'h02AA, 16'h00F0);
			else
				gs_chk(16'h03FF, 16'h0001, 16'h0200);
		end
		reg_rd("ctrl", lcr_pkg::REG_CTRL, 32'h0001_0001);
		on_count(0, 1024, n);
		chk("duty_half", 32'h1, 32'(n >= 511 && n <= 513));
		on_count(1, 1024, n);
		chk("duty_b", 32'h0000_0001, n);
		on_count(2, 1024, n);
		chk("duty_c", 32'h0000_03FF, n);
		// Receiver disabled: a whole packet must pass unseen
		reg_wr(lcr_pkg::REG_CTRL, 32'h0000_0001);
		ctl.pre_n(lcr_pkg::HDR_GS10, 10'h001, 1'b0);
		ctl.send({10'h111, 10'h222, 10'h333}, 30);
		ctl.send({10'h111, 10'h222, 10'h333}, 30);
		gs_chk(16'h03FF, 16'h0001, 16'h0200);
		reg_wr(lcr_pkg::REG_CTRL, 32'h0001_0001);
		// Four committed, one rejected, ten-bit mode, idle, last header
		reg_rd("status", lcr_pkg::REG_STATUS, 32'h0401_042B);
	endtask

	// Hang guard
	initial begin
		#400000;
		errors++;
		$display("BAD watchdog expected finish seen hang");
		tally_and_finish();
	end

	initial begin
		errors      = 0;
		comparisons = 0;
		arst_n      = 1'b0;
		reg_addr    = 8'h00;
		reg_wdata   = 32'h0;
		reg_write   = 1'b0;
		reg_read    = 1'b0;
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
		s_reset();
		s_wide();
		s_hunt();
		s_skip();
		s_narrow();
		tally_and_finish();
	end
endmodule
